/* bpps_consts.vh */
// constants and register map of the balancing pin pulse sequencer
// What this block does
// - each of twelve pins follows its nibble: steady high, steady low, or 1-7 pulses
// - pulses repeat every 155 us, about 6.45 kHz
// - each pulse is 77.6 us wide
// - pulsing starts after the start command only if its check code matches
// - poll data output stays low until the pulse sequence has finished
// - start and write-config commands are ignored while pulsing
// - conversion-poll command also reports pulse sequence completion
// - write-config with good command code but bad data code clears config
// - a set discharge bit forces its pin low over the pulse config
// - clear command zeroes config and releases pins at once
`ifndef BPPS_CONSTS_VH
`define BPPS_CONSTS_VH

// register byte addresses
`define BPPS_ADDR_CMD      8'h00
`define BPPS_ADDR_CFG_LO   8'h04
`define BPPS_ADDR_CFG_HI   8'h08
`define BPPS_ADDR_DPEC     8'h0C
`define BPPS_ADDR_DISCH    8'h10
`define BPPS_ADDR_STATUS   8'h14
`define BPPS_ADDR_ACT_LO   8'h18
`define BPPS_ADDR_ACT_HI   8'h1C

// command word fields: code in 31:16, check code in 15:0
`define BPPS_CMD_CODE_MSB  31
`define BPPS_CMD_CODE_LSB  16
`define BPPS_CMD_START     16'h0A51
`define BPPS_CMD_WRITE     16'h0A52
`define BPPS_CMD_CLEAR     16'h0A53
`define BPPS_CMD_POLL      16'h0A54

// status bit positions
`define BPPS_ST_BUSY       0
`define BPPS_ST_DONE       1
`define BPPS_ST_CMD_ERR    2
`define BPPS_ST_DATA_ERR   3
`define BPPS_ST_POLL       4

// check code generator
`define BPPS_CRC_POLY      15'h4599
`define BPPS_CRC_SEED      15'h0010

// timing: period and width as printed, clock period in ns
`define BPPS_CLK_NS        50
`define BPPS_PERIOD_NS     155000
`define BPPS_WIDTH_NS      77600
`define BPPS_PERIOD_CYC    (`BPPS_PERIOD_NS / `BPPS_CLK_NS)
`define BPPS_WIDTH_CYC     ((`BPPS_WIDTH_NS + `BPPS_CLK_NS - 1) / `BPPS_CLK_NS)

// reset values
`define BPPS_CFG_RST       48'h000000000000
`define BPPS_DISCH_RST     12'h000

`endif

/* bpps_timebase.v */
// shared pulse timebase for all balancing pins
`default_nettype none
`include "bpps_consts.vh"

module bpps_timebase #(
  parameter integer PERIOD_CYC = `BPPS_PERIOD_CYC,
  parameter integer WIDTH_CYC  = `BPPS_WIDTH_CYC
) (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       start_i,
  input  wire       abort_i,
  input  wire [2:0] max_n_i,
  output reg        busy_o,
  output reg  [2:0] idx_o,
  output wire       in_width_o
);

  // counts are cut to the 12-bit counter on purpose; 3100 cycles fit
  localparam [31:0] LAST_C32  = PERIOD_CYC - 1;
  localparam [31:0] WIDTH_C32 = WIDTH_CYC;
  localparam [11:0] LAST_CYC  = LAST_C32[11:0];
  localparam [11:0] WIDTH_C12 = WIDTH_C32[11:0];

  reg [11:0] cnt_ff;
  reg [2:0]  max_ff;

  // low phase of each pulse spans the first width cycles of a period
  assign in_width_o = busy_o && (cnt_ff < WIDTH_C12);

  // period counter; one pulse index per period, stop after longest train
  always @(posedge sys_clk_i) begin
    if (rst_i || abort_i) begin
      busy_o <= 1'b0;
      idx_o  <= 3'h0;
      cnt_ff <= 12'h000;
      max_ff <= 3'h0;
    end else if (!busy_o) begin
      if (start_i && max_n_i != 3'h0) begin
        busy_o <= 1'b1;
        idx_o  <= 3'h0;
        cnt_ff <= 12'h000;
        max_ff <= max_n_i;
      end
    end else if (cnt_ff == LAST_CYC) begin
      cnt_ff <= 12'h000;
      idx_o  <= idx_o + 3'h1;
      if (idx_o + 3'h1 == max_ff) begin
        busy_o <= 1'b0;
      end
    end else begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end

endmodule
`default_nettype wire

/* bpps_pin_logic.v */
// per-pin level selection from nibble, timebase and discharge bits
`default_nettype none

module bpps_pin_logic #(
  parameter integer PINS = 12
) (
  input  wire [4*PINS-1:0] cfg_i,
  input  wire [PINS-1:0]   disch_i,
  input  wire              busy_i,
  input  wire [2:0]        idx_i,
  input  wire              in_width_i,
  output wire [PINS-1:0]   level_o
);

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      wire [3:0] nib;
      wire       pulse_low;
      assign nib = cfg_i[4*g+3:4*g];
      // pulse k is low while index k is below the nibble count
      assign pulse_low = busy_i && in_width_i && (idx_i < nib[2:0]);
      // discharge forces low; 1xxx steady low; 0000 steady high
      assign level_o[g] = disch_i[g] ? 1'b0 :
                          nib[3]     ? 1'b0 :
                          !pulse_low;
    end
  endgenerate

endmodule
`default_nettype wire

/* bpps_top.v */
// balancing pin pulse sequencer: command decode, config storage, pin outputs
`default_nettype none
`include "bpps_consts.vh"

module bpps_top #(
  parameter integer PINS       = 12,
  parameter integer PERIOD_CYC = `BPPS_PERIOD_CYC,
  parameter integer WIDTH_CYC  = `BPPS_WIDTH_CYC
) (
  input  wire              sys_clk_i,
  input  wire              rst_i,
  input  wire [7:0]        addr_i,
  input  wire [31:0]       wdata_i,
  input  wire              wr_i,
  input  wire              rd_i,
  output reg  [31:0]       rdata_o,
  output reg  [PINS-1:0]   s_pin_o,
  output reg               poll_sdo_o,
  output reg               busy_o
);

  // register map, byte addresses:
  //   00 command word, write only: code in 31:16, check code in 15:0
  //   04 staged pulse config, pins 0-7, one nibble each
  //   08 staged pulse config, pins 8-11 in bits 15:0
  //   0C data check code over the 48 staged bits
  //   10 discharge bits, one per pin
  //   14 status: busy, done, command error, data error, poll pending
  //   18 active pulse config, pins 0-7, read only
  //   1C active pulse config, pins 8-11, read only
  //   status bits 2 and 3 clear on a write of one; a new error in the
  //   same cycle wins over the clear
  // the staged config only reaches the pins through a write command whose
  // data check code matches, so a torn update of the two halves is never
  // driven onto the converters

  // check code over the low nbits of data, msb first, result left aligned
  // one routine serves the command word and the 48 staged config bits
  function [15:0] crc_calc;
    input [47:0] data;
    input integer nbits;
    reg   [14:0] rem;
    reg          fb;
    integer      i;
    begin
      rem = `BPPS_CRC_SEED;
      for (i = 47; i >= 0; i = i - 1) begin
        if (i < nbits) begin
          fb  = data[i] ^ rem[14];
          rem = {rem[13:0], 1'b0};
          if (fb) begin
            rem = rem ^ `BPPS_CRC_POLY;
          end
        end
      end
      crc_calc = {rem, 1'b0};
    end
  endfunction

  // configuration state
  reg [47:0]     cfg_ff;
  reg [47:0]     stage_ff;
  reg [15:0]     dpec_ff;
  reg [PINS-1:0] disch_ff;
  reg            cmd_err_ff;
  reg            data_err_ff;
  reg            done_ff;
  reg            poll_ff;
  reg            start_ff;
  reg            abort_ff;
  reg [2:0]      max_n_ff;

  // next values for the control state, built by the decode below
  reg [47:0]     nxt_cfg;
  reg            nxt_cmd_err;
  reg            nxt_data_err;
  reg            nxt_start;
  reg            nxt_abort;
  reg            nxt_poll;
  reg [31:0]     nxt_rdata;
  reg [2:0]      nxt_max_n;

  // timebase and pin logic results
  wire           tb_busy;
  wire [2:0]     tb_idx;
  wire           tb_width;
  wire [PINS-1:0] pin_level;
  wire           seq_busy;
  wire           start_real;

  // command word split
  // the command's own check code covers its 16 code bits alone
  wire [15:0] cmd_code;
  wire [15:0] cmd_pec;
  wire        cmd_wr;
  wire        cmd_ok;
  wire        data_ok;

  assign cmd_code = wdata_i[`BPPS_CMD_CODE_MSB:`BPPS_CMD_CODE_LSB];
  assign cmd_pec  = wdata_i[15:0];
  assign cmd_wr   = wr_i && (addr_i == `BPPS_ADDR_CMD);
  assign cmd_ok   = (crc_calc({32'h00000000, cmd_code}, 16) == cmd_pec);
  assign data_ok  = (crc_calc(stage_ff, 48) == dpec_ff);

  // a start only counts when some pin asks for pulses; an empty start would
  // otherwise flash busy for one cycle and clear done with nothing to do
  assign start_real = start_ff && (max_n_ff != 3'h0);

  // a start is in flight from its accepting write until the timebase runs
  assign seq_busy = tb_busy || start_real;

  // longest train among pins with a pulse nibble
  // steady-low nibbles (bit 3 set) never extend the sequence
  integer k;
  always @* begin
    nxt_max_n = 3'h0;
    for (k = 0; k < PINS; k = k + 1) begin
      if (!cfg_ff[4*k+3] && cfg_ff[4*k +: 3] > nxt_max_n) begin
        nxt_max_n = cfg_ff[4*k +: 3];
      end
    end
  end

  // command decode
  always @* begin
    nxt_cfg      = cfg_ff;
    nxt_cmd_err  = cmd_err_ff;
    nxt_data_err = data_err_ff;
    nxt_start    = 1'b0;
    nxt_abort    = 1'b0;
    nxt_poll     = poll_ff;
    // write one to clear the error flags; a new error below wins
    if (wr_i && addr_i == `BPPS_ADDR_STATUS) begin
      if (wdata_i[`BPPS_ST_CMD_ERR]) begin
        nxt_cmd_err = 1'b0;
      end
      if (wdata_i[`BPPS_ST_DATA_ERR]) begin
        nxt_data_err = 1'b0;
      end
    end
    // no command may act on a corrupt word
    if (cmd_wr && !cmd_ok) begin
      nxt_cmd_err = 1'b1; // bad command code: nothing else happens
    end else if (cmd_wr) begin
      case (cmd_code)
        // start only from idle, so a running train is never restarted mid-pulse
        `BPPS_CMD_START: begin
          if (!seq_busy) begin
            nxt_start = 1'b1;
          end
        end
        // write only from idle; a bad data code wipes the active config
        `BPPS_CMD_WRITE: begin
          if (!seq_busy) begin
            if (data_ok) begin
              nxt_cfg = stage_ff;
            end else begin
              nxt_cfg      = `BPPS_CFG_RST;
              nxt_data_err = 1'b1;
            end
          end
        end
        // clear works at any time, even in the middle of a train
        `BPPS_CMD_CLEAR: begin
          nxt_cfg   = `BPPS_CFG_RST;
          nxt_abort = 1'b1;
        end
        // poll only marks the host as waiting; the flag drops with busy
        `BPPS_CMD_POLL: begin
          nxt_poll = 1'b1;
        end
        default: begin
          nxt_cmd_err = nxt_cmd_err;
        end
      endcase
    end
  end

  // register read mux; unmapped addresses read zero
  // read data stands only in the cycle after the read strobe
  always @* begin
    nxt_rdata = 32'h00000000;
    case (addr_i)
      `BPPS_ADDR_CFG_LO: nxt_rdata = stage_ff[31:0];
      `BPPS_ADDR_CFG_HI: nxt_rdata = {16'h0000, stage_ff[47:32]};
      `BPPS_ADDR_DPEC:   nxt_rdata = {16'h0000, dpec_ff};
      `BPPS_ADDR_DISCH:  nxt_rdata = {{(32-PINS){1'b0}}, disch_ff};
      `BPPS_ADDR_STATUS: begin
        nxt_rdata[`BPPS_ST_BUSY]     = seq_busy;
        nxt_rdata[`BPPS_ST_DONE]     = done_ff && !seq_busy;
        nxt_rdata[`BPPS_ST_CMD_ERR]  = cmd_err_ff;
        nxt_rdata[`BPPS_ST_DATA_ERR] = data_err_ff;
        nxt_rdata[`BPPS_ST_POLL]     = poll_ff;
      end
      `BPPS_ADDR_ACT_LO: nxt_rdata = cfg_ff[31:0];
      `BPPS_ADDR_ACT_HI: nxt_rdata = {16'h0000, cfg_ff[47:32]};
      default:           nxt_rdata = 32'h00000000;
    endcase
  end

  // staging, discharge and read data registers
  // staging writes are free at any time; only the write command moves them to the pins
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage_ff <= `BPPS_CFG_RST;
      dpec_ff  <= 16'h0000;
      disch_ff <= `BPPS_DISCH_RST;
      rdata_o  <= 32'h00000000;
    end else begin
      if (wr_i && addr_i == `BPPS_ADDR_CFG_LO) begin
        stage_ff[31:0] <= wdata_i;
      end
      if (wr_i && addr_i == `BPPS_ADDR_CFG_HI) begin
        stage_ff[47:32] <= wdata_i[15:0];
      end
      if (wr_i && addr_i == `BPPS_ADDR_DPEC) begin
        dpec_ff <= wdata_i[15:0];
      end
      if (wr_i && addr_i == `BPPS_ADDR_DISCH) begin
        disch_ff <= wdata_i[PINS-1:0];
      end
      rdata_o <= rd_i ? nxt_rdata : 32'h00000000;
    end
  end

  // control state
  // start and abort are one-cycle strobes into the timebase
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_ff      <= `BPPS_CFG_RST;
      cmd_err_ff  <= 1'b0;
      data_err_ff <= 1'b0;
      start_ff    <= 1'b0;
      abort_ff    <= 1'b0;
      poll_ff     <= 1'b0;
      max_n_ff    <= 3'h0;
    end else begin
      cfg_ff      <= nxt_cfg;
      cmd_err_ff  <= nxt_cmd_err;
      data_err_ff <= nxt_data_err;
      start_ff    <= nxt_start;
      abort_ff    <= nxt_abort;
      max_n_ff    <= nxt_max_n;
      // poll mode ends once the sequence is over
      poll_ff     <= nxt_poll && seq_busy;
    end
  end

  // done: set when a sequence ends or aborts, cleared by a new start
  // an empty start leaves done set, since no train was ever launched
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b1;
    end else if (start_real) begin
      done_ff <= 1'b0;
    end else if (!tb_busy) begin
      done_ff <= 1'b1;
    end
  end

  // one counter paces every pin, so all trains start on the same edge
  bpps_timebase #(
    .PERIOD_CYC (PERIOD_CYC),
    .WIDTH_CYC  (WIDTH_CYC)
  ) u_timebase (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .start_i    (start_ff),
    .abort_i    (abort_ff),
    .max_n_i    (max_n_ff),
    .busy_o     (tb_busy),
    .idx_o      (tb_idx),
    .in_width_o (tb_width)
  );

  // per-pin level selection; discharge bits win over every nibble
  bpps_pin_logic #(
    .PINS       (PINS)
  ) u_pins (
    .cfg_i      (cfg_ff),
    .disch_i    (disch_ff),
    .busy_i     (tb_busy),
    .idx_i      (tb_idx),
    .in_width_i (tb_width),
    .level_o    (pin_level)
  );

  // registered outputs; poll data low while a sequence runs
  // all outputs come from flops so the pins never glitch on decode changes
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_pin_o    <= {PINS{1'b1}};
      poll_sdo_o <= 1'b1;
      busy_o     <= 1'b0;
    end else begin
      s_pin_o    <= pin_level;
      poll_sdo_o <= !seq_busy;
      busy_o     <= seq_busy;
    end
  end

endmodule
`default_nettype wire

/* bpps_monitor.sv */
// port checker for the balancing pin pulse sequencer
`default_nettype none
`include "bpps_consts.vh"
module bpps_monitor #(
  parameter int PINS       = 12,
  parameter int PERIOD_CYC = 10,
  parameter int WIDTH_CYC  = 5
) (
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire logic [7:0]      addr_i,
  input wire logic [31:0]     wdata_i,
  input wire logic            wr_i,
  input wire logic            rd_i,
  input wire logic [31:0]     rdata_o,
  input wire logic [PINS-1:0] s_pin_o,
  input wire logic            poll_sdo_o,
  input wire logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MAXB = 7 * PERIOD_CYC + 4;
  logic [7:0] lo_ff;
  logic [7:0] hi_ff;
  wire        st = wr_i && addr_i == `BPPS_ADDR_CMD && wdata_i[31:16] == `BPPS_CMD_START;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // run lengths of pin 0 low and high, saturating
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lo_ff <= 8'hFF;
      hi_ff <= 8'hFF;
    end else begin
      lo_ff <= s_pin_o[0] ? 8'h00 : lo_ff + {7'h00, lo_ff != 8'hFF};
      hi_ff <= !s_pin_o[0] ? 8'h00 : hi_ff + {7'h00, hi_ff != 8'hFF};
    end
  end
  a_reset_state: assert property (disable iff (1'b0) rst_i |=> s_pin_o == '1 && !busy_o && poll_sdo_o)
    else $error("outputs not at reset levels");
  a_rdata_slot: assert property (rdata_o != 32'h0 |-> $past(rd_i)) else $error("read data outside slot");
  a_poll_busy: assert property (poll_sdo_o == !busy_o) else $error("poll out not inverse of busy");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("sequence too short");
  a_busy_max: assert property ($rose(busy_o) |-> ##[1:MAXB] !busy_o) else $error("sequence too long");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(st, 2) || $past(st, 3))
    else $error("busy without start command");
  a_pulse_width: assert property ($rose(s_pin_o[0]) && busy_o |-> lo_ff == WIDTH_CYC)
    else $error("pulse width wrong");
  a_pulse_gap: assert property ($fell(s_pin_o[0]) && $past(busy_o, 2) && hi_ff < PERIOD_CYC
    |-> hi_ff == PERIOD_CYC - WIDTH_CYC) else $error("pulse spacing wrong");
  // main scenarios seen
  c_start: cover property ($rose(busy_o));
  c_end: cover property ($fell(busy_o));
  c_read: cover property (rdata_o != 32'h0);
endmodule
bind bpps_top bpps_monitor #(.PINS(PINS), .PERIOD_CYC(PERIOD_CYC), .WIDTH_CYC(WIDTH_CYC)) i_mon (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .s_pin_o(s_pin_o), .poll_sdo_o(poll_sdo_o), .busy_o(busy_o));
`default_nettype wire

/* bpps_conv_model.sv */
// converter model: counts mode pulses arriving on each pin
`default_nettype none
module bpps_conv_model #(
  parameter int PINS = 12
) (
  input wire logic              sys_clk_i,
  input wire logic              clr_i,
  input wire logic [PINS-1:0]   s_pin_i,
  output var logic [3*PINS-1:0] cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PINS-1:0] last_ff;
  // each falling pin edge is one mode pulse
  always @(posedge sys_clk_i) begin
    last_ff <= s_pin_i;
    for (int n = 0; n < PINS; n++) begin
      if (clr_i) cnt_o[3*n +: 3] <= 3'h0;
      else if (last_ff[n] && !s_pin_i[n]) cnt_o[3*n +: 3] <= cnt_o[3*n +: 3] + 3'h1;
    end
  end
endmodule
`default_nettype wire

/* tb_balancing_pin_pulse_sequencer.sv */
// self-checking bench for the balancing pin pulse sequencer
`default_nettype none
`include "bpps_consts.vh"
module tb_balancing_pin_pulse_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 10;
  localparam int W = 5;
  typedef struct packed { logic [47:0] cfg; int len; } bpps_row_t;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, clr = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rv;
  logic [11:0] s_pin_o;
  logic        poll_sdo_o, busy_o;
  logic [35:0] cnt;
  int          n_errors = 0, total_checks = 0;
  time         t_up, t_dn;
  // pin 10 is high in row 1 and low only from row 2, so its fall in row 2 is seen
  bpps_row_t   rows [4] = '{'{48'h1, 1}, '{48'h8088_8888_8037, 7}, '{48'h0800_0765_4321, 7}, '{48'h5000_0000_0002, 5}};
  bpps_top #(.PINS(12), .PERIOD_CYC(P), .WIDTH_CYC(W)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .s_pin_o(s_pin_o), .poll_sdo_o(poll_sdo_o),
    .busy_o(busy_o));
  bpps_conv_model #(.PINS(12)) i_conv (.sys_clk_i(sys_clk_i), .clr_i(clr), .s_pin_i(s_pin_o), .cnt_o(cnt));
  // clock and busy edge times
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge busy_o) t_up = $time;
  always @(negedge busy_o) t_dn = $time;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] packet_check_code(input logic [47:0] d, input int nb);
    logic [14:0] c;
    c = 15'h0010;
    for (int i = nb - 1; i >= 0; i--) c = {c[13:0], 1'b0} ^ ((d[i] ^ c[14]) ? 15'h4599 : 15'h0000);
    return {c, 1'b0};
  endfunction
  // steady level per pin in the first pulse slot, and pulses each pin should see
  function automatic logic [11:0] lvl(input logic [47:0] c);
    for (int n = 0; n < 12; n++) lvl[n] = c[4*n +: 4] == 4'h0;
  endfunction
  function automatic logic [35:0] npl(input logic [47:0] c);
    for (int n = 0; n < 12; n++) npl[3*n +: 3] = c[4*n+3] ? 3'h1 : c[4*n +: 3];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic cmd(input logic [15:0] c, input logic [15:0] bad);
    wr(`BPPS_ADDR_CMD, {c, packet_check_code({32'h0, c}, 16) ^ bad});
  endtask
  task automatic cfg(input logic [47:0] v, input logic [15:0] bad);
    wr(`BPPS_ADDR_CFG_LO, v[31:0]);
    wr(`BPPS_ADDR_CFG_HI, {16'h0, v[47:32]});
    wr(`BPPS_ADDR_DPEC, {16'h0, packet_check_code(v, 48) ^ bad});
    cmd(`BPPS_CMD_WRITE, 16'h0);
  endtask
  task automatic act(input logic [47:0] e);
    logic [31:0] lo;
    rd(`BPPS_ADDR_ACT_LO);
    lo = rv;
    rd(`BPPS_ADDR_ACT_HI);
    chk({rv[15:0], lo}, e);
  endtask
  task automatic wait_busy(input logic v);
    for (int k = 0; k < 200 && busy_o !== v; k++) @(posedge sys_clk_i) #1;
    chk(busy_o, v);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 chk({s_pin_o, poll_sdo_o, busy_o}, {12'hFFF, 2'b10});
    rd(`BPPS_ADDR_STATUS);
    chk(rv[1], 1'b1);
    rd(8'hF0);
    chk(rv, 32'h0);
    $display("reset test done");
    // table of pulse configurations, discharge bits kept zero
    foreach (rows[r]) begin
      clr <= 1'b1;
      cfg(rows[r].cfg, 16'h0);
      clr <= 1'b0;
      act(rows[r].cfg);
      cmd(`BPPS_CMD_START, 16'h0);
      wait_busy(1'b1);
      @(posedge sys_clk_i) #1 chk(s_pin_o, lvl(rows[r].cfg));
      if (rows[r].len > 4) begin
        cmd(`BPPS_CMD_POLL, 16'h0);
        rd(`BPPS_ADDR_STATUS);
        chk({rv[4], rv[0], poll_sdo_o}, 3'b110);
        cmd(`BPPS_CMD_START, 16'h0);
        cfg(48'h0, 16'h0);
        act(rows[r].cfg);
      end
      wait_busy(1'b0);
      // busy also covers the cycle in which the start is taken
      chk((t_dn - t_up) / 50, rows[r].len * P + 1);
      chk(cnt, npl(rows[r].cfg));
      rd(`BPPS_ADDR_STATUS);
      chk({rv[4], rv[1]}, 2'b01);
      $display("row %0d done", r);
    end
    // start with a bad command code, then clear the flag
    cmd(`BPPS_CMD_START, 16'h0001);
    repeat (4) @(posedge sys_clk_i);
    chk(busy_o, 1'b0);
    rd(`BPPS_ADDR_STATUS);
    chk(rv[2], 1'b1);
    wr(`BPPS_ADDR_STATUS, 32'h4);
    rd(`BPPS_ADDR_STATUS);
    chk(rv[2], 1'b0);
    $display("bad command test done");
    // good command code, bad data code
    cfg(48'h1234, 16'h0001);
    act(48'h0);
    rd(`BPPS_ADDR_STATUS);
    chk(rv[3], 1'b1);
    $display("bad data test done");
    // discharge bits force pins low over a steady high field
    wr(`BPPS_ADDR_DISCH, 32'h005);
    repeat (3) @(posedge sys_clk_i);
    chk(s_pin_o, 12'hFFA);
    wr(`BPPS_ADDR_DISCH, 32'h000);
    repeat (3) @(posedge sys_clk_i);
    chk(s_pin_o, 12'hFFF);
    $display("discharge test done");
    // clear in the middle of a long sequence
    cfg(48'h70, 16'h0);
    cmd(`BPPS_CMD_START, 16'h0);
    wait_busy(1'b1);
    repeat (15) @(posedge sys_clk_i);
    cmd(`BPPS_CMD_CLEAR, 16'h0);
    repeat (5) @(posedge sys_clk_i);
    #1 chk({busy_o, s_pin_o}, {1'b0, 12'hFFF});
    act(48'h0);
    $display("clear test done");
    test_done;
  end
endmodule
`default_nettype wire
